/* bench/acs_chk.sv */
// port assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module acs_chk (
   // clock, reset and register port
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // core side and interrupts
   input wire logic       conv_clk,
   input wire logic       conv_enable,
   input wire logic       conv_start,
   input wire logic [2:0] conv_channel,
   input wire logic       done_irq,
   input wire logic       sys_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire logic cw = reg_wr && reg_addr == 3'h0;
   logic      spd;
   always_ff @(posedge sys_clk) begin
      if (!rstn) spd <= 1'b0;
      else if (cw) spd <= reg_wdata[6];
   end
   AST_CH: assert property (cw |=> conv_channel == $past(reg_wdata[2:0]))
      else $error("channel not taken");
   AST_ON: assert property (cw |=> conv_enable == $past(reg_wdata[5]))
      else $error("on bit not taken");
   AST_START: assert property (cw && reg_wdata[5] && !conv_enable
      |-> ##2 conv_start) else $error("no start");
   AST_CHG: assert property (cw && reg_wdata[5] && conv_enable
      && reg_wdata[2:0] != conv_channel |-> ##2 conv_start)
      else $error("no restart");
   AST_OFF: assert property (!conv_enable [*2] |-> !conv_clk)
      else $error("clock while off");
   AST_DIV: assert property ($rose(conv_clk) |-> ##[1:2] !conv_clk)
      else $error("clock high too long");
   AST_DIV2: assert property ($rose(conv_clk) && !spd
      |=> !conv_clk ##1 (conv_clk || !$past(conv_enable)))
      else $error("clock not half rate");
   AST_DIV4: assert property ($rose(conv_clk) && spd
      |=> !conv_clk [*3] ##1 (conv_clk || !$past(conv_enable)))
      else $error("clock not quarter rate");
   AST_LOW: assert property (reg_rd && reg_addr == 3'h2
      |=> reg_rdata[7:2] == 6'h00) else $error("low byte top bits");
   AST_HICLR: assert property (reg_rd && reg_addr == 3'h1 && !conv_enable
      |=> !done_irq) else $error("flag not cleared");
   AST_IEOFF: assert property (cw && !reg_wdata[4] |=> !done_irq)
      else $error("masked interrupt");
   cover property ($rose(done_irq));
   cover property ($rose(sys_irq));
   cover property (cw && reg_wdata[5]);
endmodule : acs_chk
bind acs_ctrl acs_chk acs_chk_i (.sys_clk, .rstn, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .conv_clk, .conv_enable, .conv_start,
   .conv_channel, .done_irq, .sys_irq);
`default_nettype wire

/* bench/acs_core_model.sv */
// conversion core model with settable latency
`timescale 1ns/100ps
`default_nettype none
module acs_core_model (
   // block side
   input  wire logic       sys_clk,
   input  wire logic       conv_start,
   input  wire logic       conv_enable,
   input  wire logic [2:0] conv_channel,
   // bench knobs and answer
   input  wire logic [7:0] lat,
   input  wire logic [9:0] val,
   output var  logic       conv_done = 1'b0,
   output var  logic [9:0] conv_result = 10'h000
);
   logic [7:0] cnt = 8'h00;
   logic       busy = 1'b0;
   always @(posedge sys_clk) begin
      conv_done <= 1'b0;
      if (conv_start) begin
         busy <= 1'b1;
         cnt <= lat;
         // old value no longer held
         conv_result <= ~conv_result;
      end else if (!conv_enable)
         busy <= 1'b0;
      else if (busy && cnt == 8'h00) begin
         busy <= 1'b0;
         conv_done <= 1'b1;
         conv_result <= val ^ {7'h00, conv_channel};
      end else if (busy)
         cnt <= cnt - 8'h01;
   end
endmodule : acs_core_model
`default_nettype wire

/* bench/acs_ctrl_tb.sv */
// random and corner stimulus for the converter control block
`timescale 1ns/100ps
`default_nettype none
module acs_ctrl_tb;
   logic        sys_clk, rstn, reg_wr, reg_rd, conv_done, conv_clk;
   logic        conv_enable, conv_start, done_irq, sys_irq;
   logic [2:0]  reg_addr, conv_channel;
   logic [7:0]  reg_wdata, reg_rdata, lat, ctl;
   logic [9:0]  conv_result, val, r;
   logic [31:0] lf = 32'h51f0;
   int          miscompares = 0;
   int          total_checks = 0;
   acs_ctrl acs_ctrl_i (.sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .conv_clk, .conv_enable, .conv_start,
      .conv_channel, .conv_done, .conv_result, .done_irq, .sys_irq);
   acs_core_model acs_core_model_i (.sys_clk, .conv_start, .conv_enable,
      .conv_channel, .lat, .val, .conv_done, .conv_result);
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   function automatic logic [7:0] rb(input logic [9:0] v, input logic h);
      return h ? v[9:2] : {6'h00, v[1:0]};
   endfunction : rb
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [7:0] d, input logic [7:0] e);
      {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
      @(posedge sys_clk);
      {reg_wr, reg_rd} <= 2'b00;
      @(negedge sys_clk);
      if (!w) chk(reg_rdata, e);
      @(posedge sys_clk);
   endtask : bus
   // wait for done status, then look at the core side
   task automatic wt(input logic ie, input logic [2:0] ch);
      int n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (sys_irq !== 1'b1 && n < 300);
      if (sys_irq !== 1'b1) begin
         miscompares++;
         final_report;
      end else begin
         chk({7'h00, done_irq}, {7'h00, ie});
         chk({5'h00, conv_channel}, {5'h00, ch});
         @(posedge sys_clk);
      end
   endtask : wt
   initial begin
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, lat, val} = '0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      for (int a = 0; a < 7; a++)
         if (a != 5) bus(1'b0, a[2:0], 8'h00, 8'h00);
      bus(1'b1, 3'h4, 8'h01, 8'h00);
      repeat (4) begin
         lf = nxt(lf);
         bus(1'b1, 3'h0, lf[7:0] & 8'hdf | 8'h80, 8'h00);
         bus(1'b0, 3'h0, 8'h00, lf[7:0] & 8'h5f);
      end
      for (int c = 0; c < 8; c++) begin
         lf = nxt(lf);
         {val, lat} <= {lf[9:0], 3'h0, lf[14:10]};
         r = lf[9:0] ^ {7'h00, c[2:0]};
         ctl = {1'b0, lf[15], 1'b1, c[0], 1'b1, c[2:0]};
         bus(1'b1, 3'h0, ctl, 8'h00);
         wt(c[0], c[2:0]);
         bus(1'b0, 3'h0, 8'h00, ctl & 8'h5f | 8'h80);
         bus(1'b0, 3'h2, 8'h00, rb(r, 1'b0));
         bus(1'b0, 3'h1, 8'h00, rb(r, 1'b1));
         bus(1'b0, 3'h0, 8'h00, ctl & 8'h5f);
         bus(1'b1, 3'h5, 8'h01, 8'h00);
      end
      {val, lat} <= {10'h2a5, 8'h14};
      bus(1'b1, 3'h0, 8'h23, 8'h00);
      wt(1'b0, 3'h3);
      bus(1'b1, 3'h5, 8'h01, 8'h00);
      bus(1'b0, 3'h2, 8'h00, rb(10'h2a6, 1'b0));
      val <= 10'h15a;
      wt(1'b0, 3'h3);
      bus(1'b0, 3'h1, 8'h00, rb(10'h2a6, 1'b1));
      bus(1'b1, 3'h5, 8'h01, 8'h00);
      wt(1'b0, 3'h3);
      bus(1'b0, 3'h1, 8'h00, rb(10'h159, 1'b1));
      bus(1'b1, 3'h0, 8'h25, 8'h00);
      bus(1'b0, 3'h3, 8'h00, 8'h03);
      bus(1'b1, 3'h5, 8'h03, 8'h00);
      wt(1'b0, 3'h5);
      bus(1'b0, 3'h1, 8'h00, rb(10'h15a ^ 10'h005, 1'b1));
      bus(1'b1, 3'h0, 8'h00, 8'h00);
      final_report;
   end
endmodule : acs_ctrl_tb
`default_nettype wire

/* verilog/acs_ctrl.sv */
// converter control, status and result registers with core handshake
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - the done flag in control bit 7 sets on completion and clears when the high result byte is read.
// - control bit 7 ignores writes while all other control bits are read and write.
// - setting the on bit enables and starts, clearing it stops, and a single conversion end clears it.
// - control bit 4 lets the completion interrupt through on done_irq when set and blocks it there when clear; sys_irq does not use it.
// - control bit 3 selects continuous conversion at 0 and one conversion per start at 1.
// - control bits 2 to 0 choose analog channel 0 to 7 in plain binary.
// - the low result byte shows result bits 1 and 0 low and zeros above.
// - a channel change during a conversion abandons it and starts the new channel.
// - reading the low byte locks both result bytes until the high byte is read or the on bit clears.
// - continuous mode reconverts without end and each result stands until the next completes.
module acs_ctrl
   import acs_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   // register port
   input  wire logic [2:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   // conversion core
   output var  logic       conv_clk,
   output var  logic       conv_enable,
   output var  logic       conv_start,
   output var  logic [2:0] conv_channel,
   input  wire logic       conv_done,
   input  wire logic [9:0] conv_result,
   // interrupts
   output var  logic       done_irq,
   output var  logic       sys_irq
);

   localparam int ST_W_M1 = ACS_ST_W - 1;

   typedef struct packed {
      logic [7:0]         ctrl;
      logic [9:0]         result;
      logic               locked;
      acs_state_e         state;
      logic               done_seen;
      logic [1:0]         div_cnt;
      logic               conv_clk;
      logic               conv_start;
      logic [7:0]         rdata;
      logic [ST_W_M1:0]   stat;
      logic [ST_W_M1:0]   irq_en;
      logic               done_irq;
      logic               sys_irq;
   } acs_regs_s;

   acs_regs_s  cur_reg;
   acs_regs_s  cur_next;
   logic       done_sync;
   logic [9:0] res_sync;

   acs_sync u_done_sync (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .async_in (conv_done),
      .sync_out (done_sync)
   );

   // result bits take the same two stages as the done level, so the
   // word is steady by the time the synced edge is acted on
   for (genvar i = 0; i < $bits(res_sync); i++) begin : g_res_sync
      acs_sync u_res_sync (
         .sys_clk  (sys_clk),
         .rstn     (rstn),
         .async_in (conv_result[i]),
         .sync_out (res_sync[i])
      );
   end

   // wire outputs straight from the state flip-flops
   assign reg_rdata    = cur_reg.rdata;
   assign conv_clk     = cur_reg.conv_clk;
   assign conv_enable  = cur_reg.ctrl[ACS_BIT_ON];
   assign conv_start   = cur_reg.conv_start;
   assign conv_channel = cur_reg.ctrl[ACS_CH_MSB:0];
   assign done_irq     = cur_reg.done_irq;
   assign sys_irq      = cur_reg.sys_irq;

   always_comb begin
      logic       wr_ctrl;
      logic       wr_irq_en;
      logic       wr_irq_clr;
      logic       rd_high;
      logic       rd_low;
      logic       ch_change;
      logic       done_edge;
      logic       finish;
      logic       abort_ev;
      logic       restart;
      logic [7:0] new_ctrl;
      logic [ST_W_M1:0] ev;

      cur_next  = cur_reg;
      wr_ctrl   = reg_wr && (reg_addr == {1'b0, ACS_IDX_CTRL});
      rd_high   = reg_rd && (reg_addr == {1'b0, ACS_IDX_RES_HIGH});
      rd_low    = reg_rd && (reg_addr == {1'b0, ACS_IDX_RES_LOW});
      wr_irq_en  = reg_wr && (reg_addr == ACS_ADDR_IRQ_EN);
      wr_irq_clr = reg_wr && (reg_addr == ACS_ADDR_IRQ_CLR);
      done_edge = done_sync && !cur_reg.done_seen;
      new_ctrl  = cur_reg.ctrl;
      finish    = 1'b0;
      abort_ev  = 1'b0;
      restart   = 1'b0;
      ch_change = 1'b0;
      ev        = '0;

      cur_next.done_seen  = done_sync;
      cur_next.conv_start = 1'b0;

      // converter clock divider
      if (!cur_reg.ctrl[ACS_BIT_ON]) begin
         cur_next.div_cnt  = 2'h0;
         cur_next.conv_clk = 1'b0;
      end else if (cur_reg.div_cnt == (cur_reg.ctrl[ACS_BIT_SPEED] ?
                   ACS_DIV4_LAST : ACS_DIV2_LAST)) begin
         cur_next.div_cnt  = 2'h0;
         cur_next.conv_clk = 1'b1;
      end else begin
         cur_next.div_cnt  = cur_reg.div_cnt + 2'h1;
         cur_next.conv_clk = (cur_reg.div_cnt == 2'h0) ? 1'b0 :
                             cur_reg.conv_clk;
      end

      // conversion sequencing
      unique case (cur_reg.state)
         ACS_IDLE: begin
            if (cur_reg.ctrl[ACS_BIT_ON]) begin
               cur_next.state = ACS_START;
            end
         end
         ACS_START: begin
            cur_next.conv_start = 1'b1;
            cur_next.state      = ACS_WAIT;
         end
         ACS_WAIT: begin
            if (done_edge) begin
               finish = 1'b1;
               if (cur_reg.ctrl[ACS_BIT_SINGLE]) begin
                  new_ctrl[ACS_BIT_ON] = 1'b0;
                  cur_next.state       = ACS_IDLE;
               end else begin
                  restart = 1'b1;
               end
            end
         end
         default: begin
            cur_next.state = ACS_IDLE;
         end
      endcase

      if (finish) begin
         new_ctrl[ACS_BIT_DONE] = 1'b1;
         ev[ACS_ST_DONE]        = 1'b1;
         if (!cur_reg.locked) begin
            cur_next.result = res_sync;
         end
      end
      if (restart) begin
         cur_next.state = ACS_START;
      end

      // software write to control; done flag kept by hardware
      if (wr_ctrl) begin
         ch_change = (reg_wdata[ACS_CH_MSB:0] != cur_reg.ctrl[ACS_CH_MSB:0]);
         new_ctrl  = (reg_wdata & ACS_WR_MASK) |
                     (new_ctrl & ~ACS_WR_MASK);
         if (!reg_wdata[ACS_BIT_ON]) begin
            cur_next.state = ACS_IDLE;
            if (cur_reg.state != ACS_IDLE) begin
               abort_ev = 1'b1;
            end
         end else if (!cur_reg.ctrl[ACS_BIT_ON]) begin
            cur_next.state = ACS_START;
         end else if (ch_change && cur_reg.state != ACS_IDLE) begin
            cur_next.state = ACS_START;
            abort_ev       = 1'b1;
         end
      end

      // high byte read clears done; a set in the same cycle wins
      if (rd_high && !finish) begin
         new_ctrl[ACS_BIT_DONE] = 1'b0;
      end
      cur_next.ctrl = new_ctrl;

      // result lock
      if (rd_low) begin
         cur_next.locked = 1'b1;
      end
      if (rd_high || !new_ctrl[ACS_BIT_ON]) begin
         cur_next.locked = 1'b0;
      end
      ev[ACS_ST_ABORT] = abort_ev;

      // read data, valid one cycle after the strobe
      cur_next.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            {1'b0, ACS_IDX_CTRL}:     cur_next.rdata = cur_reg.ctrl;
            {1'b0, ACS_IDX_RES_HIGH}: cur_next.rdata =
                                         cur_reg.result[9:2];
            {1'b0, ACS_IDX_RES_LOW}:  cur_next.rdata =
                                         {6'h00, cur_reg.result[1:0]};
            ACS_ADDR_STAT:            cur_next.rdata =
                                         {6'h00, cur_reg.stat};
            ACS_ADDR_IRQ_EN:          cur_next.rdata =
                                         {6'h00, cur_reg.irq_en};
            default:                  cur_next.rdata = 8'h00;
         endcase
      end

      // sticky event status, set wins over clear
      if (wr_irq_en) begin
         cur_next.irq_en = reg_wdata[ST_W_M1:0];
      end
      if (wr_irq_clr) begin
         cur_next.stat = (cur_reg.stat & ~reg_wdata[ST_W_M1:0]) | ev;
      end else begin
         cur_next.stat = cur_reg.stat | ev;
      end

      cur_next.done_irq = new_ctrl[ACS_BIT_DONE] &&
                          new_ctrl[ACS_BIT_IE];
      cur_next.sys_irq  = |(cur_next.stat & cur_next.irq_en);
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cur_reg.ctrl       <= ACS_CTRL_RST;
         cur_reg.result     <= ACS_RES_RST;
         cur_reg.locked     <= 1'b0;
         cur_reg.state      <= ACS_IDLE;
         cur_reg.done_seen  <= 1'b0;
         cur_reg.div_cnt    <= 2'h0;
         cur_reg.conv_clk   <= 1'b0;
         cur_reg.conv_start <= 1'b0;
         cur_reg.rdata      <= 8'h00;
         cur_reg.stat       <= '0;
         cur_reg.irq_en     <= '0;
         cur_reg.done_irq   <= 1'b0;
         cur_reg.sys_irq    <= 1'b0;
      end else begin
         cur_reg <= cur_next;
      end
   end
endmodule : acs_ctrl
`default_nettype wire

/* verilog/acs_pkg.sv */
// constants, register map and state types of the converter control block
package acs_pkg;
   // register indices on the plain register port
   localparam logic [1:0] ACS_IDX_CTRL      = 2'h0;
   localparam logic [1:0] ACS_IDX_RES_HIGH  = 2'h1;
   localparam logic [1:0] ACS_IDX_RES_LOW   = 2'h2;
   localparam logic [1:0] ACS_IDX_IRQ_STAT  = 2'h3;
   localparam int         ACS_ADDR_W        = 2;
   // full addresses: status on the first page, interrupt enable and clear on the second
   localparam logic [2:0] ACS_ADDR_STAT     = 3'h3;
   localparam logic [2:0] ACS_ADDR_IRQ_EN   = 3'h4;
   localparam logic [2:0] ACS_ADDR_IRQ_CLR  = 3'h5;
   // control field positions
   localparam int ACS_BIT_DONE    = 7;
   localparam int ACS_BIT_SPEED   = 6;
   localparam int ACS_BIT_ON      = 5;
   localparam int ACS_BIT_IE      = 4;
   localparam int ACS_BIT_SINGLE  = 3;
   localparam int ACS_CH_MSB      = 2;
   // status bit positions
   localparam int ACS_ST_DONE     = 0;
   localparam int ACS_ST_ABORT    = 1;
   localparam int ACS_ST_W        = 2;
   // reset values and control write mask
   localparam logic [7:0] ACS_CTRL_RST = 8'h00;
   localparam logic [9:0] ACS_RES_RST  = 10'h000;
   localparam logic [7:0] ACS_WR_MASK  = 8'h7F;
   // converter clock division
   localparam logic [1:0] ACS_DIV2_LAST = 2'h1;
   localparam logic [1:0] ACS_DIV4_LAST = 2'h3;

   typedef enum logic [1:0] {
      ACS_IDLE  = 2'b00,
      ACS_START = 2'b01,
      ACS_WAIT  = 2'b10
   } acs_state_e;
endpackage : acs_pkg

/* verilog/acs_sync.sv */
// two flip-flop synchroniser for one level from the conversion core
`timescale 1ns/100ps
`default_nettype none
module acs_sync (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // level in and out
   input  wire logic async_in,
   output var  logic sync_out
);
   logic meta_reg;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : acs_sync
`default_nettype wire
